//--- rtl/hbsd_defines.vh
// Constants for the host bus strap decode block
`ifndef HBSD_DEFINES_VH
`define HBSD_DEFINES_VH

// Bus-select strap codes
`define HBSD_BUS_GENERIC   2'h0
`define HBSD_BUS_RESERVED  2'h1
`define HBSD_BUS_ENABLE_RW 2'h2
`define HBSD_BUS_ADDR_STB  2'h3

// Shift-ratio strap codes
`define HBSD_RATIO_X1      2'h0
`define HBSD_RATIO_X2      2'h1
`define HBSD_RATIO_X4      2'h2
`define HBSD_RATIO_RSVD    2'h3

// Colour depth codes (bits 1-0 of the colour depth register)
`define HBSD_DEPTH_1BPP    2'h0
`define HBSD_DEPTH_2BPP    2'h1
`define HBSD_DEPTH_4BPP    2'h2
`define HBSD_DEPTH_RSVD    2'h3

// Smallest shift clock ratio (4:1) and divider width
`define HBSD_BASE_RATIO    7'h04
`define HBSD_DIV_W         7

// Panel type bit 0: STN or TFT
`define HBSD_PANEL_TFT     1'h1

// Cycles after reset release before straps are captured
`define HBSD_SETTLE_CYC    2'h3

// Cycles from strobe to acknowledge
`define HBSD_ACK_CYC       4'h3

// Synchroniser reset: bus strobes idle high
`define HBSD_SYNC_RST      32'h000000F0

`endif

//--- rtl/hbsd_shift_div.v
// Panel shift clock divider with a programmable ratio
`timescale 1ns/1ps
`default_nettype none
`include "hbsd_defines.vh"

module hbsd_shift_div #(
  parameter DIV_W = `HBSD_DIV_W
) (
  input  wire             clk_sys_i,
  input  wire             rst_i,
  input  wire             enable_i,
  input  wire [DIV_W-1:0] ratio_i,
  output reg              shift_clk_o
);

  reg [DIV_W-1:0] cnt_q;
  wire [DIV_W-1:0] half_w;

  assign half_w = {1'b0, ratio_i[DIV_W-1:1]};

  // ============================================================
  // Divide input clock by the ratio, 50 percent duty
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q       <= {DIV_W{1'b0}};
      shift_clk_o <= 1'b0;
    end else if (!enable_i) begin
      cnt_q       <= {DIV_W{1'b0}};
      shift_clk_o <= 1'b0;
    end else if (cnt_q >= half_w - 1'b1) begin
      cnt_q       <= {DIV_W{1'b0}};
      shift_clk_o <= ~shift_clk_o;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule
`default_nettype wire

//--- rtl/hbsd_top.v
// Strap decode, host bus front end and shift clock generation
//Contract
// - Addressing strap high selects indirect mode with one address line and eight data lines.
// - Addressing strap low selects direct mode with sixteen address lines and eight data lines.
// - Bus-select 00 is the generic strobe bus, 01 reserved, 10 enable plus read/write, 11 address/data strobe.
// - At one bit per pixel the ratio straps give 4:1, 8:1, 16:1, with 11 reserved.
// - At two bits per pixel the ratio straps give 8:1, 16:1, 32:1, with 11 reserved.
// - At four bits per pixel the ratio straps give 16:1, 32:1, 64:1, with 11 reserved.
// - In the address-strobe bus the wait pin acts as a transfer acknowledge.
// - The panel shift clock is the input clock divided by the strap-selected ratio.
// - Panel type bit 0 selects STN when 0 and TFT when 1.
`timescale 1ns/1ps
`default_nettype none
`include "hbsd_defines.vh"

module hbsd_top #(
  parameter DIV_W = `HBSD_DIV_W
) (
  input  wire             clk_sys_i,
  input  wire             rst_i,
  input  wire             addr_mode_strap_i,
  input  wire [1:0]       bus_select_straps_i,
  input  wire [1:0]       shift_ratio_straps_i,
  input  wire [1:0]       color_depth_i,
  input  wire             panel_type_i,
  input  wire [15:0]      host_addr_i,
  input  wire [7:0]       host_data_i,
  output reg  [7:0]       host_data_o,
  output reg              host_data_oe_o,
  input  wire             host_cs_n_i,
  input  wire             address_strobe_n_i,
  input  wire             host_rd_n_i,
  input  wire             host_wr_n_i,
  output reg              transfer_ack_n_o,
  output reg              transfer_ack_oe_o,
  output reg  [15:0]      reg_addr_o,
  output reg  [7:0]       reg_wdata_o,
  output reg              reg_wr_o,
  output reg              reg_rd_o,
  input  wire [7:0]       reg_rdata_i,
  output reg              cfg_ready_o,
  output reg              cfg_invalid_o,
  output reg              cfg_tft_ratio_bad_o,
  output reg              indirect_mode_o,
  output reg  [1:0]       bus_mode_o,
  output reg              panel_tft_o,
  output reg  [DIV_W-1:0] shift_ratio_o,
  output wire             panel_shift_clock_o
);

  localparam ST_IDLE = 2'b00;
  localparam ST_BUSY = 2'b01;
  localparam ST_DONE = 2'b10;

  // ============================================================
  // Two-flop synchronisers for host bus pins and the addressing and bus-select straps
  reg [31:0] sync1_q;
  reg [31:0] sync2_q;
  wire [31:0] pins_w;

  assign pins_w = {host_addr_i, host_data_i, host_cs_n_i, address_strobe_n_i,
                   host_rd_n_i, host_wr_n_i, addr_mode_strap_i, bus_select_straps_i,
                   1'b0};

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= `HBSD_SYNC_RST;
      sync2_q <= `HBSD_SYNC_RST;
    end else begin
      sync1_q <= pins_w;
      sync2_q <= sync1_q;
    end
  end

  wire [15:0] s_addr  = sync2_q[31:16];
  wire [7:0]  s_data  = sync2_q[15:8];
  wire        s_cs_n  = sync2_q[7];
  wire        s_as_n  = sync2_q[6];
  wire        s_rd_n  = sync2_q[5];
  wire        s_wr_n  = sync2_q[4];
  wire        s_amode = sync2_q[3];
  wire [1:0]  s_bus   = sync2_q[2:1];

  // Ratio straps through their own pair
  reg [1:0] ratio_s1_q;
  reg [1:0] ratio_s2_q;

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ratio_s1_q <= 2'h0;
      ratio_s2_q <= 2'h0;
    end else begin
      ratio_s1_q <= shift_ratio_straps_i;
      ratio_s2_q <= ratio_s1_q;
    end
  end

  // ============================================================
  // Ratio lookup
  function [DIV_W-1:0] ratio_of;
    input [1:0] code;
    input [1:0] depth;
    reg   [DIV_W-1:0] base;
    begin
      base = `HBSD_BASE_RATIO << code;
      ratio_of = base << depth;
    end
  endfunction

  // ============================================================
  // Strap capture after reset release
  reg [1:0] settle_q;
  reg       amode_q;
  reg [1:0] bus_q;
  reg [1:0] ratio_q;

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      settle_q    <= 2'h0;
      cfg_ready_o <= 1'b0;
      amode_q     <= 1'b0;
      bus_q       <= `HBSD_BUS_GENERIC;
      ratio_q     <= `HBSD_RATIO_X1;
    end else if (!cfg_ready_o) begin
      if (settle_q == `HBSD_SETTLE_CYC) begin
        cfg_ready_o <= 1'b1;
        amode_q     <= s_amode;
        bus_q       <= s_bus;
        ratio_q     <= ratio_s2_q;
      end else begin
        settle_q <= settle_q + 2'h1;
      end
    end
  end

  // ============================================================
  // Decoded configuration outputs
  reg         invalid_d;
  reg [DIV_W-1:0] ratio_d;

  always @* begin
    ratio_d = ratio_of(ratio_q, color_depth_i);
    invalid_d = (bus_q == `HBSD_BUS_RESERVED) ||
                (ratio_q == `HBSD_RATIO_RSVD) ||
                (color_depth_i == `HBSD_DEPTH_RSVD) ||
                ((bus_q == `HBSD_BUS_ENABLE_RW) && !amode_q);
  end

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_invalid_o       <= 1'b0;
      cfg_tft_ratio_bad_o <= 1'b0;
      indirect_mode_o     <= 1'b0;
      bus_mode_o          <= `HBSD_BUS_GENERIC;
      panel_tft_o         <= 1'b0;
      shift_ratio_o       <= `HBSD_BASE_RATIO;
    end else begin
      cfg_invalid_o   <= cfg_ready_o & invalid_d;
      indirect_mode_o <= amode_q;
      bus_mode_o      <= bus_q;
      panel_tft_o     <= (panel_type_i == `HBSD_PANEL_TFT);
      cfg_tft_ratio_bad_o <= cfg_ready_o & (panel_type_i == `HBSD_PANEL_TFT) &
                             (ratio_q != `HBSD_RATIO_X1);
      shift_ratio_o   <= ratio_d;
    end
  end

  // ============================================================
  // Panel shift clock
  // divided from the input clock
  hbsd_shift_div #(
    .DIV_W (DIV_W)
  ) u_div (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .enable_i    (cfg_ready_o & ~cfg_invalid_o),
    .ratio_i     (shift_ratio_o),
    .shift_clk_o (panel_shift_clock_o)
  );

  // ============================================================
  // Host bus strobe decode per protocol
  reg strobe_w;
  reg read_w;

  always @* begin
    strobe_w = 1'b0;
    read_w   = 1'b0;
    case (bus_q)
      `HBSD_BUS_GENERIC: begin
        strobe_w = ~s_cs_n & (~s_rd_n | ~s_wr_n);
        read_w   = ~s_rd_n;
      end
      `HBSD_BUS_ENABLE_RW: begin
        strobe_w = ~s_cs_n & s_rd_n;
        read_w   = s_wr_n;
      end
      `HBSD_BUS_ADDR_STB: begin
        strobe_w = ~s_cs_n & ~s_as_n & ~s_rd_n;
        read_w   = s_wr_n;
      end
      default: begin
        strobe_w = 1'b0;
        read_w   = 1'b0;
      end
    endcase
    strobe_w = strobe_w & cfg_ready_o & ~invalid_d;
  end

  // ============================================================
  // Access sequencer
  reg [1:0] state_q;
  reg [3:0] cnt_q;
  reg       is_read_q;

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q           <= ST_IDLE;
      cnt_q             <= 4'h0;
      is_read_q         <= 1'b0;
      reg_addr_o        <= 16'h0000;
      reg_wdata_o       <= 8'h00;
      reg_wr_o          <= 1'b0;
      reg_rd_o          <= 1'b0;
      host_data_o       <= 8'h00;
      host_data_oe_o    <= 1'b0;
      transfer_ack_n_o  <= 1'b1;
      transfer_ack_oe_o <= 1'b0;
    end else begin
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          transfer_ack_n_o  <= 1'b1;
          transfer_ack_oe_o <= 1'b0;
          host_data_oe_o    <= 1'b0;
          if (strobe_w) begin
            state_q   <= ST_BUSY;
            cnt_q     <= 4'h0;
            is_read_q <= read_w;
            reg_addr_o <= amode_q ? {15'h0000, s_addr[0]} : s_addr;
            reg_wdata_o <= s_data;
            reg_rd_o   <= read_w;
            // Generic wait held low while busy
            transfer_ack_oe_o <= (bus_q == `HBSD_BUS_GENERIC);
            transfer_ack_n_o  <= 1'b0;
          end
        end
        ST_BUSY: begin
          if (!strobe_w) begin
            state_q <= ST_IDLE;
          end else if (cnt_q == `HBSD_ACK_CYC) begin
            state_q  <= ST_DONE;
            reg_wr_o <= ~is_read_q;
            host_data_o    <= reg_rdata_i;
            host_data_oe_o <= is_read_q;
            transfer_ack_oe_o <= (bus_q == `HBSD_BUS_GENERIC) ||
                                 (bus_q == `HBSD_BUS_ADDR_STB);
            transfer_ack_n_o  <= (bus_q == `HBSD_BUS_GENERIC);
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        ST_DONE: begin
          if (!strobe_w) begin
            state_q           <= ST_IDLE;
            host_data_oe_o    <= 1'b0;
            transfer_ack_n_o  <= 1'b1;
            transfer_ack_oe_o <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- sim/hbsd_checker.sv
// Port assertions for the strap decode block
`timescale 1ns/1ps
`default_nettype none
module hbsd_checker #(
  parameter DIV_W = 7
) (
  input wire logic             clk_sys_i,
  input wire logic             rst_i,
  input wire logic             reg_wr_o,
  input wire logic             reg_rd_o,
  input wire logic             cfg_ready_o,
  input wire logic             cfg_invalid_o,
  input wire logic [1:0]       bus_mode_o,
  input wire logic             indirect_mode_o,
  input wire logic [DIV_W-1:0] shift_ratio_o,
  input wire logic             transfer_ack_oe_o,
  input wire logic             transfer_ack_n_o,
  input wire logic             panel_shift_clock_o
);
  logic [DIV_W-1:0] gap_q;
  logic             prev_q;
  logic             seen_q;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // ==========
  // Cycles since last shift clock edge
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      gap_q  <= '0;
      prev_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      prev_q <= panel_shift_clock_o;
      seen_q <= seen_q | (panel_shift_clock_o != prev_q);
      gap_q  <= (panel_shift_clock_o != prev_q) ? '0 : gap_q + 1'b1;
    end
  end
  // ==========
  // Properties
  a_wr_one_pulse:
  assert property (reg_wr_o |=> !reg_wr_o) else $error("write pulse too long");
  a_rd_one_pulse:
  assert property (reg_rd_o |=> !reg_rd_o) else $error("read pulse too long");
  a_strobe_bus_ack:
  assert property (bus_mode_o == 2'h3 && transfer_ack_oe_o |-> !transfer_ack_n_o) else $error("ack level wrong");
  a_invalid_no_access:
  assert property (cfg_invalid_o |-> !reg_wr_o && !reg_rd_o) else $error("access while invalid");
  a_unready_no_access:
  assert property (!cfg_ready_o |-> !reg_wr_o && !reg_rd_o) else $error("access before ready");
  a_cfg_held:
  assert property (cfg_ready_o && $past(cfg_ready_o, 2) |-> $stable(bus_mode_o) && $stable(indirect_mode_o)
    && $stable(shift_ratio_o)) else $error("decode changed");
  a_enable_bus_no_ack:
  assert property (cfg_ready_o && bus_mode_o == 2'h2 |-> !transfer_ack_oe_o) else $error("ack driven");
  a_bad_bus_invalid:
  assert property (cfg_ready_o && $past(cfg_ready_o) && (bus_mode_o == 2'h1 || (bus_mode_o == 2'h2
    && !indirect_mode_o)) |-> cfg_invalid_o) else $error("bad bus not flagged");
  a_shift_idle_low:
  assert property ((!cfg_ready_o || cfg_invalid_o) [*2] |-> !panel_shift_clock_o) else $error("shift runs");
  a_shift_half_period:
  assert property (seen_q && panel_shift_clock_o != prev_q |-> gap_q == (shift_ratio_o >> 1) - 1'b1)
    else $error("shift period wrong");
endmodule
bind hbsd_top hbsd_checker #(.DIV_W(DIV_W)) chk_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_wr_o(reg_wr_o),
  .reg_rd_o(reg_rd_o), .cfg_ready_o(cfg_ready_o), .cfg_invalid_o(cfg_invalid_o), .bus_mode_o(bus_mode_o),
  .indirect_mode_o(indirect_mode_o), .shift_ratio_o(shift_ratio_o), .transfer_ack_oe_o(transfer_ack_oe_o),
  .transfer_ack_n_o(transfer_ack_n_o),
  .panel_shift_clock_o(panel_shift_clock_o));
`default_nettype wire

//--- sim/hbsd_host_model.sv
// Behavioural host CPU making single-byte reads and writes
`timescale 1ns/1ps
`default_nettype none
module hbsd_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic        go_i,
  input  wire logic        rd_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        ack_n_i,
  input  wire logic        ack_oe_i,
  output logic             cs_n_o,
  output logic             as_n_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic [15:0]      addr_o,
  output logic [7:0]       data_o,
  output logic             done_o
);
  logic act = 1'b0;
  int   n;
  assign cs_n_o = !act;
  assign as_n_o = !(act && mode_i == 2'h3);
  // Enable-bus strobe idles low, others idle high
  assign rd_n_o = act ? (mode_i == 2'h3 ? 1'b0 : (mode_i == 2'h2 || !rd_i)) : mode_i != 2'h2;
  // Generic write strobe, or read-not-write line
  assign wr_n_o = !act || rd_i;
  initial begin
    addr_o = '0;
    data_o = '0;
    done_o = 1'b0;
  end
  always begin
    @(negedge clk_sys_i);
    if (!go_i) begin
      done_o = 1'b0;
    end else if (!done_o) begin
      addr_o = addr_i;
      data_o = data_i;
      act = 1'b1;
      n = 0;
      do begin
        @(posedge clk_sys_i);
        n++;
      end while (!(ack_oe_i && (ack_n_i != (mode_i == 2'h3))) && n < 40);
      @(negedge clk_sys_i);
      act = 1'b0;
      addr_o = ~addr_o;
      data_o = ~data_o;
      done_o = 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- sim/hbsd_tb_top.sv
// Self-checking bench for the strap decode block
`timescale 1ns/1ps
`default_nettype none
module hbsd_tb_top;
  localparam int LIMIT = 30000;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        am, pt, go, cs_n, as_n, rd_n, wr_n, ackn, ackoe, oe, wr, rd, rdy, inv, tbad, ind, tft, sclk, done;
  logic [1:0]  bs, ra, dp, bm;
  logic [15:0] ha, pa, raddr;
  logic [7:0]  hw, hd, pd, dout, wdat, rdat;
  logic [6:0]  sr;
  logic        rdy_q, pend, rsel, oe_q;
  int          failures, compares, cyc;
  logic [12:0] cq[$];
  logic [23:0] wq[$], rq[$];
  always #2 clk = ~clk;
  hbsd_top dut_u (.clk_sys_i(clk), .rst_i(rst), .addr_mode_strap_i(am), .bus_select_straps_i(bs),
    .shift_ratio_straps_i(ra), .color_depth_i(dp), .panel_type_i(pt), .host_addr_i(pa), .host_data_i(hd),
    .host_data_o(dout), .host_data_oe_o(oe), .host_cs_n_i(cs_n), .address_strobe_n_i(as_n),
    .host_rd_n_i(rd_n), .host_wr_n_i(wr_n), .transfer_ack_n_o(ackn), .transfer_ack_oe_o(ackoe),
    .reg_addr_o(raddr), .reg_wdata_o(wdat), .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdat),
    .cfg_ready_o(rdy), .cfg_invalid_o(inv), .cfg_tft_ratio_bad_o(tbad), .indirect_mode_o(ind),
    .bus_mode_o(bm), .panel_tft_o(tft), .shift_ratio_o(sr), .panel_shift_clock_o(sclk));
  hbsd_host_model host_u (.clk_sys_i(clk), .go_i(go), .rd_i(rsel), .mode_i(bs), .addr_i(ha), .data_i(hw),
    .ack_n_i(ackoe ? ackn : 1'b1), .ack_oe_i(ackoe), .cs_n_o(cs_n), .as_n_o(as_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .addr_o(pa), .data_o(pd), .done_o(done));
  assign hd = oe ? dout : pd;
  task automatic tally(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic cmp_cfg(input logic [12:0] got, input logic [12:0] exp);
    tally(exp[12] ? got[12:9] === exp[12:9] : got === exp, "decoded config");
  endtask
  task automatic cmp_wr(input logic [23:0] got, input logic [23:0] exp);
    tally(got === exp, "register write");
  endtask
  task automatic cmp_rd(input logic [23:0] got, input logic [23:0] exp);
    tally(got === exp, "register read");
  endtask
  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========
  // Result monitor
  always @(posedge clk) begin
    rdy_q <= rdy;
    pend <= rdy & ~rdy_q;
    if (pend) cmp_cfg({inv, ind, bm, sr, tft, tbad}, cq.size() ? cq.pop_front() : 'x);
    if (wr) cmp_wr({raddr, wdat}, wq.size() ? wq.pop_front() : 'x);
    oe_q <= oe;
    if (oe && !oe_q) cmp_rd({raddr, dout}, rq.size() ? rq.pop_front() : 'x);
    cyc++;
    if (cyc == LIMIT) begin
      failures++;
      final_report();
    end
  end
  task automatic run_test(input logic [1:0] b, input logic [1:0] r, input logic [1:0] d);
    logic v;
    int   n;
    @(negedge clk);
    rst = 1'b1;
    bs = b;
    ra = r;
    dp = d;
    am = $urandom;
    pt = $urandom;
    ha = $urandom;
    hw = $urandom;
    rdat = $urandom;
    rsel = $urandom;
    if (am) ha[15:1] = '0;
    v = b != 2'h1 && r != 2'h3 && d != 2'h3 && !(b == 2'h2 && !am);
    cq.push_back({!v, am, b, 7'h04 << ({1'b0, r} + d), pt, pt && r != 2'h0});
    repeat (6) @(negedge clk);
    rst = 1'b0;
    for (n = 0; n < 20 && !rdy; n++) @(negedge clk);
    repeat (3) @(negedge clk);
    if (v && rsel) rq.push_back({ha, rdat});
    else if (v) wq.push_back({ha, hw});
    go = 1'b1;
    for (n = 0; n < 60 && !done; n++) @(negedge clk);
    go = 1'b0;
    repeat (150) @(negedge clk);
    tally(cq.size() == 0 && wq.size() == 0 && rq.size() == 0, "result missing");
  endtask
  initial begin
    {am, pt, go, rsel, bs, ra, dp, ha, hw, rdat} = '0;
    {failures, compares, cyc} = '0;
    void'($urandom(46));
    for (int i = 0; i < 64; i++) begin
      run_test(i[1:0], i[3:2], i[5:4]);
      $display("test %0d done", i);
    end
    final_report();
  end
endmodule
`default_nettype wire
